// ### dcr_ctrl.sv
// Disconnect, reconnect and burst control toward the block multiplexer channel
// How it works
// R1: Hold operational-in through whole burst transfer.
// R2: Track has 128 sectors numbered 00-7F.
// R3: Per-drive counter steps each period, index clears.
// R4: Current sector of every drive is visible.
// R5: Set sector accepted, then disconnect from channel.
// R6: Read sector returns prior record's sector.
// R7: Seek and set sector disconnect despite chaining.
// R8: Separate disconnected chain context per drive.
// R9: Seek reconnect starts when motion done.
// R10: Set sector reconnect starts at matching sector.
// R11: Retry procedure may also disconnect.
// R12: Drive ready after disconnect raises request-in.
// R13: Busy channel: request stays pending, keep waiting.
// R14: Channel saves restart context on disconnect.
// R15: Channel reloads context on accepted reconnect.
// R16: Reconnects served in order of readiness.
// R17: Channel answers request-in with select and hold.
// R18: Answer: block select, drop request, raise op/addr.
// R19: After service-out drop status, then operational.
// R20: Compare target at each update while pending.
`timescale 1ns/100ps
`default_nettype none
module dcr_ctrl #(
   parameter int NDRV = dcr_pkg::NUM_DRIVES,
   parameter int SECTOR_CYC = dcr_pkg::SECTOR_CYCLES,
   parameter logic [4:0] UNIT_ADDR = dcr_pkg::UNIT_ADDR_DEFAULT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Channel interface pins
   input wire dcr_pkg::dcr_tags_out_t chan_tags,
   output dcr_pkg::dcr_tags_in_t dev_tags,
   output logic [7:0] bus_in,
   // Command sequencer
   input wire logic cmd_valid,
   input wire dcr_pkg::dcr_cmd_t cmd,
   input wire logic xfer_done,
   input wire logic [NDRV-1:0] retry_done,
   output logic cmd_ready,
   output logic [dcr_pkg::SECTOR_W-1:0] read_sector,
   output logic [dcr_pkg::DRV_W-1:0] recon_drive,
   // Drive pins
   input wire logic [NDRV-1:0] index_mark,
   input wire logic [NDRV-1:0] seek_done,
   // Current sector of every drive
   output logic [NDRV*dcr_pkg::SECTOR_W-1:0] sector_now
);
   import dcr_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_BURST = 3'b001,
      ST_REQ = 3'b010,
      ST_ADDR = 3'b011,
      ST_CMDW = 3'b100,
      ST_STS = 3'b101,
      ST_SVCW = 3'b110
   } dcr_state_t;

   dcr_state_t st_q;
   dcr_tags_out_t tags_m_q, tags_s_q;
   logic [NDRV-1:0] idx_m_q, idx_s_q, seek_m_q, seek_s_q;
   logic [SECTOR_W-1:0] cur_sec [NDRV];
   logic [NDRV-1:0] match;
   logic [NDRV-1:0] arm;
   logic [NDRV-1:0] wait_seek_q, wait_retry_q, wait_set_q;
   logic [NDRV-1:0] pend_q;
   logic [DRV_W-1:0] rank_q [NDRV];
   logic [SECTOR_W-1:0] last_rec_q [NDRV];
   logic [NDRV-1:0] event_v;
   logic [DRV_W-1:0] head_drv;
   logic head_ok;
   logic take;
   logic done_recon;

   assign take = cmd_valid && (st_q == ST_IDLE);
   assign done_recon = (st_q == ST_SVCW) && !tags_s_q.service_out;

   // Two-stage synchronisers for channel tags and drive pins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tags_m_q <= '0;
         tags_s_q <= '0;
         idx_m_q <= '0;
         idx_s_q <= '0;
         seek_m_q <= '0;
         seek_s_q <= '0;
      end else begin
         tags_m_q <= chan_tags;
         tags_s_q <= tags_m_q;
         idx_m_q <= index_mark;
         idx_s_q <= idx_m_q;
         seek_m_q <= seek_done;
         seek_s_q <= seek_m_q;
      end
   end

   // One sector tracker per drive
   for (genvar g = 0; g < NDRV; g++) begin : g_drv
      assign arm[g] = take && cmd.op == DCR_OP_SET_SECTOR && cmd.drive == DRV_W'(g);
      dcr_sector_track #(.SECTOR_CYC(SECTOR_CYC)) u_trk (
         .clk(clk),
         .reset_n(reset_n),
         .index_s(idx_s_q[g]),
         .arm(arm[g]),
         .target(cmd.sector),
         .sector_q(cur_sec[g]),
         .match_q(match[g])
      );
      assign event_v[g] = (wait_seek_q[g] && seek_s_q[g]) // R9
         || (wait_set_q[g] && match[g]) // R10
         || (wait_retry_q[g] && retry_done[g]);
   end

   // Oldest pending reconnect is the one ranked zero
   always_comb begin
      head_ok = 1'b0;
      head_drv = '0;
      for (int i = NDRV - 1; i >= 0; i--) begin
         if (pend_q[i] && rank_q[i] == '0) begin
            head_ok = 1'b1;
            head_drv = DRV_W'(i);
         end
      end
   end

   // Per-drive disconnected-chain context
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_seek_q <= '0;
         wait_set_q <= '0;
         wait_retry_q <= '0;
      end else begin
         for (int i = 0; i < NDRV; i++) begin
            if (event_v[i]) begin
               wait_seek_q[i] <= 1'b0;
               wait_set_q[i] <= 1'b0;
               wait_retry_q[i] <= 1'b0;
            end else if (take && cmd.drive == DRV_W'(i)) begin
               wait_seek_q[i] <= (cmd.op == DCR_OP_SEEK); // R8
               wait_set_q[i] <= (cmd.op == DCR_OP_SET_SECTOR); // R8
               wait_retry_q[i] <= (cmd.op == DCR_OP_RETRY); // R11
            end
         end
      end
   end

   // Pending reconnects ranked by arrival, same-cycle ties by drive number
   always_ff @(posedge clk or negedge reset_n) begin
      int base;
      int n;
      if (!reset_n) begin
         pend_q <= '0;
         for (int i = 0; i < NDRV; i++) begin
            rank_q[i] <= '0;
         end
      end else begin
         base = 0;
         n = 0;
         for (int i = 0; i < NDRV; i++) begin
            if (pend_q[i] && !(done_recon && recon_drive == DRV_W'(i))) begin
               base = base + 1;
            end
         end
         for (int i = 0; i < NDRV; i++) begin
            if (event_v[i]) begin
               pend_q[i] <= 1'b1; // R12
               rank_q[i] <= DRV_W'(base + n); // R16
               n = n + 1;
            end else if (done_recon && recon_drive == DRV_W'(i)) begin
               pend_q[i] <= 1'b0;
            end else if (done_recon && pend_q[i]) begin
               rank_q[i] <= rank_q[i] - DRV_W'(1); // R16
            end
         end
      end
   end

   // Sector of each record handled by a data command
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NDRV; i++) begin
            last_rec_q[i] <= SECTOR_FIRST;
         end
         read_sector <= SECTOR_FIRST;
      end else begin
         if (take && cmd.op == DCR_OP_DATA) begin
            last_rec_q[cmd.drive] <= cur_sec[cmd.drive];
         end
         if (take && cmd.op == DCR_OP_READ_SECTOR) begin
            read_sector <= last_rec_q[cmd.drive]; // R6
         end
      end
   end

   // Registered view of all sector counters
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sector_now <= '0;
      end else begin
         for (int i = 0; i < NDRV; i++) begin
            sector_now[i*SECTOR_W +: SECTOR_W] <= cur_sec[i]; // R4
         end
      end
   end

   // Channel sequence state machine with its tag outputs
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= ST_IDLE;
         dev_tags <= '0;
         bus_in <= BUS_IDLE;
         recon_drive <= '0;
         cmd_ready <= 1'b0;
      end else begin
         dev_tags.select_pass <= tags_s_q.select_out && st_q == ST_IDLE;
         cmd_ready <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               cmd_ready <= !take && !head_ok;
               if (take && cmd.op == DCR_OP_DATA) begin
                  dev_tags.operational_in <= 1'b1; // R1
                  st_q <= ST_BURST;
               end else if (take) begin
                  dev_tags.operational_in <= 1'b0; // R5 R7
               end else if (head_ok) begin
                  recon_drive <= head_drv;
                  dev_tags.request_in <= 1'b1; // R12
                  st_q <= ST_REQ;
               end
            end
            ST_BURST: begin
               if (xfer_done) begin
                  dev_tags.operational_in <= 1'b0;
                  st_q <= ST_IDLE;
               end
            end
            ST_REQ: begin
               if (tags_s_q.select_out && tags_s_q.hold_out) begin // R13
                  dev_tags.select_pass <= 1'b0; // R18
                  dev_tags.request_in <= 1'b0; // R18
                  dev_tags.operational_in <= 1'b1; // R18
                  dev_tags.address_in <= 1'b1; // R18
                  bus_in <= {UNIT_ADDR, recon_drive}; // R18
                  st_q <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               dev_tags.select_pass <= 1'b0;
               if (tags_s_q.command_out) begin
                  dev_tags.address_in <= 1'b0;
                  bus_in <= BUS_IDLE;
                  st_q <= ST_CMDW;
               end
            end
            ST_CMDW: begin
               dev_tags.select_pass <= 1'b0;
               if (!tags_s_q.command_out) begin
                  dev_tags.status_in <= 1'b1;
                  bus_in <= STATUS_DEV_END;
                  st_q <= ST_STS;
               end
            end
            ST_STS: begin
               dev_tags.select_pass <= 1'b0;
               if (tags_s_q.service_out) begin
                  dev_tags.status_in <= 1'b0; // R19
                  bus_in <= BUS_IDLE;
                  st_q <= ST_SVCW;
               end
            end
            ST_SVCW: begin
               dev_tags.select_pass <= 1'b0;
               if (!tags_s_q.service_out) begin
                  dev_tags.operational_in <= 1'b0; // R19
                  st_q <= ST_IDLE;
               end
            end
            default: begin
               dev_tags <= '0;
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Assertion sequences
   sequence s_answer;
      dev_tags.address_in && dev_tags.operational_in && !dev_tags.request_in && !dev_tags.select_pass;
   endsequence
   sequence s_end_tags;
      (!dev_tags.status_in && dev_tags.operational_in) ##[1:8] !dev_tags.operational_in;
   endsequence

   a_burst_op_held: assert property (@(posedge clk) disable iff (!reset_n)
      st_q == ST_BURST |-> dev_tags.operational_in) // R1
      else $error("operational-in dropped during burst");
   a_setsec_disc: assert property (@(posedge clk) disable iff (!reset_n)
      (take && cmd.op == DCR_OP_SET_SECTOR) |=> !dev_tags.operational_in && st_q == ST_IDLE) // R5
      else $error("no disconnect after set sector");
   a_rdsec_value: assert property (@(posedge clk) disable iff (!reset_n)
      (take && cmd.op == DCR_OP_READ_SECTOR) |=> read_sector == $past(last_rec_q[cmd.drive])) // R6
      else $error("read sector returned wrong value");
   a_seek_recon: assert property (@(posedge clk) disable iff (!reset_n)
      (wait_seek_q & seek_s_q) != '0 |=> (pend_q & $past(wait_seek_q & seek_s_q)) == $past(wait_seek_q & seek_s_q)) // R9
      else $error("seek completion did not queue reconnect");
   a_req_pending: assert property (@(posedge clk) disable iff (!reset_n)
      (dev_tags.request_in && !(tags_s_q.select_out && tags_s_q.hold_out)) |=> dev_tags.request_in) // R13
      else $error("request-in withdrawn while waiting");
   a_addr_answer: assert property (@(posedge clk) disable iff (!reset_n)
      (st_q == ST_REQ && tags_s_q.select_out && tags_s_q.hold_out) |=> s_answer) // R18
      else $error("bad answer to reconnect selection");
   a_status_end: assert property (@(posedge clk) disable iff (!reset_n)
      (st_q == ST_STS && tags_s_q.service_out) |=> s_end_tags) // R19
      else $error("status-in/operational-in not dropped in order");
   a_fcfs_head: assert property (@(posedge clk) disable iff (!reset_n)
      (st_q == ST_IDLE && !take && head_ok) |=> recon_drive == $past(head_drv) && dev_tags.request_in) // R16
      else $error("reconnect not served oldest first");
endmodule // dcr_ctrl
`default_nettype wire

// ### dcr_pkg.sv
// Shared constants and carrier types for the disconnect/reconnect control logic
package dcr_pkg;
   // Geometry and drive count
   localparam int NUM_DRIVES = 8;
   localparam int DRV_W = 3;
   localparam int SECTOR_W = 7;
   localparam int SECTORS_PER_TRACK = 128;
   localparam logic [6:0] SECTOR_LAST = 7'h7F;
   localparam logic [6:0] SECTOR_FIRST = 7'h00;

   // Timing: sector period in ns and clock period in ns
   localparam int SECTOR_PERIOD_NS = 130000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int SECTOR_CYCLES = SECTOR_PERIOD_NS / CLK_PERIOD_NS;

   // Bus values
   localparam logic [7:0] STATUS_DEV_END = 8'h04;
   localparam logic [4:0] UNIT_ADDR_DEFAULT = 5'h00;
   localparam logic [7:0] BUS_IDLE = 8'h00;

   // Commands from the command sequencer
   typedef enum logic [2:0] {
      DCR_OP_SEEK = 3'b000,
      DCR_OP_SET_SECTOR = 3'b001,
      DCR_OP_READ_SECTOR = 3'b010,
      DCR_OP_DATA = 3'b011,
      DCR_OP_RETRY = 3'b100
   } dcr_op_t;

   // Channel-side tags seen from the host
   typedef struct packed {
      logic select_out;
      logic hold_out;
      logic command_out;
      logic service_out;
   } dcr_tags_out_t;

   // Tags driven back to the host
   typedef struct packed {
      logic operational_in;
      logic request_in;
      logic address_in;
      logic status_in;
      logic select_pass;
   } dcr_tags_in_t;

   // Command request
   typedef struct packed {
      dcr_op_t op;
      logic [DRV_W-1:0] drive;
      logic [SECTOR_W-1:0] sector;
   } dcr_cmd_t;
endpackage

// ### dcr_sector_track.sv
// Per-drive sector counter with set-sector target compare
`timescale 1ns/100ps
`default_nettype none
module dcr_sector_track #(
   parameter int SECTOR_CYC = dcr_pkg::SECTOR_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Index marker, already synchronised
   input wire logic index_s,
   // Set sector arming
   input wire logic arm,
   input wire logic [dcr_pkg::SECTOR_W-1:0] target,
   // Results
   output logic [dcr_pkg::SECTOR_W-1:0] sector_q,
   output logic match_q
);
   import dcr_pkg::*;

   logic [15:0] tick_q;
   logic index_d1_q;
   logic armed_q;
   logic [SECTOR_W-1:0] target_q;
   logic index_edge;
   logic step;

   assign index_edge = index_s & ~index_d1_q;
   assign step = (tick_q == 16'(SECTOR_CYC - 1));

   // Index edge detect
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         index_d1_q <= 1'b0;
      end else begin
         index_d1_q <= index_s;
      end
   end

   // Sector period timer and sector counter, index clears both
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_q <= 16'h0000;
         sector_q <= SECTOR_FIRST;
      end else if (index_edge) begin
         tick_q <= 16'h0000; // R3
         sector_q <= SECTOR_FIRST; // R3
      end else if (step) begin
         tick_q <= 16'h0000;
         sector_q <= sector_q + 7'h01; // R2
      end else begin
         tick_q <= tick_q + 16'h0001;
      end
   end

   // Target store and compare on each counter update
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         armed_q <= 1'b0;
         target_q <= SECTOR_FIRST;
         match_q <= 1'b0;
      end else begin
         match_q <= 1'b0;
         if (arm) begin
            armed_q <= 1'b1;
            target_q <= target;
         end else if (armed_q && step && !index_edge && (sector_q + 7'h01) == target_q) begin
            armed_q <= 1'b0; // R20
            match_q <= 1'b1; // R20
         end else if (armed_q && index_edge && target_q == SECTOR_FIRST) begin
            armed_q <= 1'b0; // R20
            match_q <= 1'b1; // R20
         end
      end
   end

   // Counter and target match checks
   a_sector_wrap: assert property (@(posedge clk) disable iff (!reset_n)
      (sector_q == SECTOR_LAST && step && !index_edge) |=> sector_q == SECTOR_FIRST) // R2
      else $error("sector counter did not wrap to zero");
   a_index_clear: assert property (@(posedge clk) disable iff (!reset_n)
      index_edge |=> (sector_q == SECTOR_FIRST && tick_q == 16'h0000)) // R3
      else $error("index did not clear sector counter");
   a_match_armed: assert property (@(posedge clk) disable iff (!reset_n)
      match_q |-> ($past(armed_q) && sector_q == $past(target_q))) // R20
      else $error("sector match without pending target");
endmodule // dcr_sector_track
`default_nettype wire

// ### dcr_chan_model.sv
// Behavioural block multiplexer channel that answers device reconnect requests
`timescale 1ns/100ps
`default_nettype none
module dcr_chan_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Holds the channel busy with other work
   input wire logic busy,
   // Device side
   input wire dcr_pkg::dcr_tags_in_t dev_tags,
   input wire logic [7:0] bus_in,
   // Channel tags
   output dcr_pkg::dcr_tags_out_t chan_tags,
   // Observation
   output logic [2:0] last_drv,
   output logic [7:0] recon_cnt
);
   import dcr_pkg::*;
   logic [2:0] st_q;
   logic [7:0] ctx_q;
   logic [7:0] saved_q [8];

   // Reconnect handshake, one tag step per device response
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= 3'd0;
         chan_tags <= '0;
         last_drv <= 3'd0;
         recon_cnt <= 8'd0;
         ctx_q <= 8'h00;
         for (int i = 0; i < 8; i++) saved_q[i] <= 8'h00;
      end else begin
         case (st_q)
            3'd0: if (dev_tags.request_in && !busy) begin
               chan_tags.select_out <= 1'b1;
               chan_tags.hold_out <= 1'b1;
               st_q <= 3'd1;
            end
            3'd1: if (dev_tags.address_in) begin
               last_drv <= bus_in[2:0];
               ctx_q <= saved_q[bus_in[2:0]];
               chan_tags.command_out <= 1'b1;
               st_q <= 3'd2;
            end
            3'd2: if (!dev_tags.address_in) begin
               chan_tags.command_out <= 1'b0;
               st_q <= 3'd3;
            end
            3'd3: if (dev_tags.status_in) begin
               chan_tags.service_out <= 1'b1;
               chan_tags.select_out <= 1'b0;
               chan_tags.hold_out <= 1'b0;
               st_q <= 3'd4;
            end
            3'd4: if (!dev_tags.status_in) begin
               chan_tags.service_out <= 1'b0;
               st_q <= 3'd5;
            end
            default: if (!dev_tags.operational_in) begin
               saved_q[last_drv] <= ctx_q + 8'h01;
               recon_cnt <= recon_cnt + 8'd1;
               st_q <= 3'd0;
            end
         endcase
      end
   end
endmodule // dcr_chan_model
`default_nettype wire

// ### channel_disconnect_reconnect_bench.sv
// Self-checking bench for the disconnect and reconnect control logic
`timescale 1ns/100ps
`default_nettype none
module channel_disconnect_reconnect_bench;
   import dcr_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic busy = 1'b0;
   logic cmd_valid = 1'b0;
   dcr_cmd_t cmd = '0;
   logic xfer_done = 1'b0;
   logic [7:0] retry_done = '0;
   logic [7:0] index_mark = '0;
   logic [7:0] seek_done = '0;
   dcr_tags_out_t chan_tags;
   dcr_tags_in_t dev_tags;
   logic [7:0] bus_in;
   logic cmd_ready;
   logic [6:0] read_sector;
   logic [2:0] recon_drive;
   logic [55:0] sector_now;
   logic [2:0] last_drv;
   logic [7:0] recon_cnt;
   logic [7:0] exp_cnt;
   int n_errors = 0;
   int compares = 0;

   // Clock at 40 MHz
   always #12.5 clk = ~clk;

   // Design under test with a short sector period
   dcr_ctrl #(.NDRV(8), .SECTOR_CYC(8), .UNIT_ADDR(UNIT_ADDR_DEFAULT)) u_dcr_ctrl (
      .clk(clk), .reset_n(reset_n), .chan_tags(chan_tags), .dev_tags(dev_tags), .bus_in(bus_in),
      .cmd_valid(cmd_valid), .cmd(cmd), .xfer_done(xfer_done), .retry_done(retry_done),
      .cmd_ready(cmd_ready), .read_sector(read_sector), .recon_drive(recon_drive),
      .index_mark(index_mark), .seek_done(seek_done), .sector_now(sector_now));

   // Channel on the far side
   dcr_chan_model u_dcr_chan_model (
      .clk(clk), .reset_n(reset_n), .busy(busy), .dev_tags(dev_tags), .bus_in(bus_in),
      .chan_tags(chan_tags), .last_drv(last_drv), .recon_cnt(recon_cnt));

   task final_report();
      $display("Checks %0d, errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [6:0] sect_of(input int i);
      return sector_now[7*i +: 7];
   endfunction

   function automatic bit cond(input int which);
      case (which)
         0: return cmd_ready === 1'b1;
         1: return dev_tags.request_in === 1'b1;
         2: return dev_tags.address_in === 1'b1;
         3: return dev_tags.status_in === 1'b1;
         default: return recon_cnt === exp_cnt;
      endcase
   endfunction

   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Bounded wait; running out counts as a mismatch and ends the run
   task wait_until(input int which);
      int i;
      for (i = 0; i < 3000 && !cond(which); i++) tick(1);
      if (!cond(which)) begin
         n_errors++;
         $display("Error wait %0d expected 1 seen 0", which);
         final_report();
      end
   endtask

   task send_cmd(input dcr_op_t op, input logic [2:0] drv, input logic [6:0] s);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= '{op: op, drive: drv, sector: s};
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
   endtask

   // Follows one reconnection and judges the device side of it
   task check_recon(input logic [2:0] drv);
      exp_cnt = recon_cnt + 8'd1;
      wait_until(1);
      wait_until(2);
      chk("bus_in address", {UNIT_ADDR_DEFAULT, drv}, bus_in);
      chk("recon_drive", drv, recon_drive);
      chk("request_in", 0, dev_tags.request_in);
      chk("select_pass", 0, dev_tags.select_pass);
      chk("operational_in", 1, dev_tags.operational_in);
      wait_until(3);
      chk("bus_in status", STATUS_DEV_END, bus_in);
      wait_until(4);
      chk("operational_in end", 0, dev_tags.operational_in);
      chk("served drive", drv, last_drv);
   endtask

   task sector_scan();
      logic [6:0] prev;
      logic [6:0] nxt;
      int wraps;
      int i;
      wraps = 0;
      prev = sect_of(0);
      for (i = 0; i < 20 && sect_of(0) === prev; i++) tick(1);
      prev = sect_of(0);
      nxt = prev + 7'd1;
      tick(8);
      chk("sector step", nxt, sect_of(0));
      chk("sector drive 5", sect_of(0), sect_of(5));
      prev = sect_of(0);
      for (i = 0; i < 1100; i++) begin
         tick(1);
         if (sect_of(0) !== prev) begin
            if (prev === SECTOR_LAST) wraps++;
            nxt = prev + 7'd1;
            chk("sector next", nxt, sect_of(0));
            prev = sect_of(0);
         end
      end
      chk("sector wrap", 1, wraps > 0);
      for (i = 0; i < 20 && sect_of(0) === prev; i++) tick(1);
      prev = sect_of(0);
      @(posedge clk) index_mark[3] <= 1'b1;
      @(posedge clk) index_mark[3] <= 1'b0;
      tick(4);
      chk("index clear", SECTOR_FIRST, sect_of(3));
      chk("other drive", prev, sect_of(0));
   endtask

   task burst_and_read_sector();
      int i;
      logic [6:0] rec_sec;
      wait_until(0);
      send_cmd(DCR_OP_DATA, 3'd1, 7'h2A);
      rec_sec = sect_of(1);
      tick(1);
      chk("burst op_in", 1, dev_tags.operational_in);
      send_cmd(DCR_OP_SET_SECTOR, 3'd3, 7'h05);
      for (i = 0; i < 20; i++) begin
         tick(1);
         chk("burst hold", 1, dev_tags.operational_in);
         chk("no request", 0, dev_tags.request_in);
      end
      @(posedge clk) xfer_done <= 1'b1;
      @(posedge clk) xfer_done <= 1'b0;
      tick(2);
      chk("burst end", 0, dev_tags.operational_in);
      wait_until(0);
      send_cmd(DCR_OP_DATA, 3'd3, 7'h11);
      @(posedge clk) xfer_done <= 1'b1;
      @(posedge clk) xfer_done <= 1'b0;
      wait_until(0);
      send_cmd(DCR_OP_READ_SECTOR, 3'd1, 7'h00);
      tick(1);
      chk("read_sector", rec_sec, read_sector);
   endtask

   task set_sector_recon();
      logic [6:0] target;
      wait_until(0);
      target = sect_of(2) + 7'd3;
      send_cmd(DCR_OP_SET_SECTOR, 3'd2, target);
      tick(1);
      chk("set sector op_in", 0, dev_tags.operational_in);
      wait_until(0);
      wait_until(1);
      chk("match sector", target, sect_of(2));
      check_recon(3'd2);
   endtask

   task seek_recon();
      int i;
      wait_until(0);
      send_cmd(DCR_OP_SEEK, 3'd4, 7'h00);
      tick(1);
      chk("seek op_in", 0, dev_tags.operational_in);
      for (i = 0; i < 20; i++) begin
         tick(1);
         chk("seek waits", 0, dev_tags.request_in);
      end
      @(posedge clk) seek_done[4] <= 1'b1;
      check_recon(3'd4);
      @(posedge clk) seek_done[4] <= 1'b0;
   endtask

   task busy_retry();
      int i;
      busy <= 1'b1;
      wait_until(0);
      send_cmd(DCR_OP_RETRY, 3'd5, 7'h00);
      @(posedge clk) retry_done[5] <= 1'b1;
      @(posedge clk) retry_done[5] <= 1'b0;
      wait_until(1);
      for (i = 0; i < 30; i++) begin
         tick(1);
         chk("request pending", 1, dev_tags.request_in);
      end
      busy <= 1'b0;
      check_recon(3'd5);
   endtask

   task fcfs_order();
      busy <= 1'b1;
      wait_until(0);
      send_cmd(DCR_OP_SEEK, 3'd6, 7'h00);
      wait_until(0);
      send_cmd(DCR_OP_SEEK, 3'd7, 7'h00);
      wait_until(0);
      send_cmd(DCR_OP_RETRY, 3'd1, 7'h00);
      @(posedge clk) seek_done[7] <= 1'b1;
      tick(3);
      @(posedge clk) retry_done[1] <= 1'b1;
      @(posedge clk) retry_done[1] <= 1'b0;
      tick(3);
      @(posedge clk) seek_done[6] <= 1'b1;
      tick(5);
      busy <= 1'b0;
      check_recon(3'd7);
      check_recon(3'd1);
      check_recon(3'd6);
      seek_done <= '0;
   endtask

   // Watchdog over the whole run
   initial begin
      #2500000;
      n_errors++;
      final_report();
   end

   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      #1;
      chk("reset tags", 0, dev_tags);
      chk("reset ready", 0, cmd_ready);
      @(posedge clk) reset_n <= 1'b1;
      tick(2);
      chk("ready after reset", 1, cmd_ready);
      sector_scan();
      burst_and_read_sector();
      set_sector_recon();
      seek_recon();
      busy_retry();
      fcfs_order();
      tick(5);
      final_report();
   end
endmodule // channel_disconnect_reconnect_bench
`default_nettype wire
